// ===== verilog/rc_adc_defines.vh
`ifndef RC_ADC_DEFINES_VH
`define RC_ADC_DEFINES_VH
// ****************************************************************
// register byte addresses
// ****************************************************************
`define ADDR_CNT_A_LOW 5'h00
`define ADDR_CNT_A_HIGH 5'h04
`define ADDR_CNT_B_LOW 5'h08
`define ADDR_CNT_B_HIGH 5'h0c
`define ADDR_TIMER_CTRL 5'h10
`define ADDR_CONV_CFG 5'h14
`define ADDR_IRQ_CTRL 5'h18
// ****************************************************************
// timer control fields
// ****************************************************************
`define BIT_MODE_HI 6
`define BIT_MODE_LO 5
`define BIT_RUN 4
`define BIT_EDGE_SEL 3
`define MODE_UNUSED 2'h0
`define MODE_EVENT 2'h1
`define MODE_TIMER 2'h2
`define MODE_PULSE 2'h3
// ****************************************************************
// converter configuration fields
// ****************************************************************
`define BIT_OSC_CHANNEL_SEL 7
`define BIT_CNT_B_SRC_SEL 6
`define BIT_LIRC_EN 5
`define BIT_RC_PATH_SEL 2
`define BIT_CONVERTER_MODE 1
`define BIT_OVERFLOW_SRC_SEL 0
// ****************************************************************
// interrupt control fields
// ****************************************************************
`define BIT_OVERFLOW_FLAG 4
// ****************************************************************
// reset values and bus answers
// ****************************************************************
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`define CNT_ALL_ONES 16'hffff
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== verilog/osc_edge_sync.v
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// two-flop synchroniser with edge pulses
// ****************************************************************
module osc_edge_sync (
    input wire aclk,
    input wire aresetn,
    input wire osc_in,
    output reg rise,
    output reg fall
);
reg meta;
reg stable;
reg stable_d;
// only the second stage and later are looked at, the first may be metastable
always @(posedge aclk) begin
    if (!aresetn) begin
        meta <= 1'b0;
        stable <= 1'b0;
        stable_d <= 1'b0;
        rise <= 1'b0;
        fall <= 1'b0;
    end else begin
        meta <= osc_in;
        stable <= meta;
        stable_d <= stable;
        rise <= stable & ~stable_d;
        fall <= ~stable & stable_d;
    end
end
endmodule // osc_edge_sync
`default_nettype wire

// ===== verilog/rc_dual_counter_adc.v
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rc_adc_defines.vh"
module rc_dual_counter_adc #(
    parameter CNT_WIDTH = 16,
    parameter TWO_OSC = 1
) (
    input wire aclk,
    input wire aresetn,
    input wire [4:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [4:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire low_speed_rc_osc,
    input wire res_freq_osc0,
    input wire res_freq_osc1,
    output wire res_freq_osc0_en,
    output wire res_freq_osc1_en,
    output wire low_speed_rc_osc_en,
    output wire sensor_resistor_path,
    output wire overflow_irq_flag
);
// ****************************************************************
// control state
// ****************************************************************
reg [CNT_WIDTH-1:0] cnt_a;
reg [CNT_WIDTH-1:0] cnt_b;
reg [7:0] buf_a;
reg [7:0] buf_b;
reg mode_sel_hi;
reg mode_sel_lo;
reg run_bit;
reg edge_sel;
reg osc_channel_sel;
reg cnt_b_src_sel;
reg lirc_en;
reg rc_path_sel;
reg converter_mode_bit;
reg overflow_src_sel;
reg flag;
wire [1:0] mode = {mode_sel_hi, mode_sel_lo};
// ****************************************************************
// oscillator power control
// ****************************************************************
// mode 10 in converter mode also needs the external oscillator when it feeds B
wire osc_on = run_bit & (mode_sel_lo | ((mode == `MODE_TIMER) & converter_mode_bit
    & cnt_b_src_sel));
assign res_freq_osc0_en = osc_on & ~(osc_channel_sel & (TWO_OSC != 0));
assign res_freq_osc1_en = osc_on & osc_channel_sel & (TWO_OSC != 0);
assign low_speed_rc_osc_en = lirc_en;
assign sensor_resistor_path = rc_path_sel;
assign overflow_irq_flag = flag;
// ****************************************************************
// counter B clock source
// ****************************************************************
wire rf_osc = (osc_channel_sel && TWO_OSC != 0) ? res_freq_osc1 : res_freq_osc0;
wire b_src = cnt_b_src_sel ? rf_osc : low_speed_rc_osc;
wire b_rise;
wire b_fall;
osc_edge_sync u_b_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_in(b_src),
    .rise(b_rise),
    .fall(b_fall)
);
// falling edge only in event mode with edge select set
wire b_edge = (mode == `MODE_EVENT && edge_sel) ? b_fall : b_rise;
// ****************************************************************
// counting and overflow
// ****************************************************************
wire counting = run_bit & converter_mode_bit;
wire inc_a = counting;
wire inc_b = counting & b_edge;
wire ovf_a = inc_a & (cnt_a == `CNT_ALL_ONES);
wire ovf_b = inc_b & (cnt_b == `CNT_ALL_ONES);
wire ovf = overflow_src_sel ? ovf_b : ovf_a;
// ****************************************************************
// AXI4-Lite write side
// ****************************************************************
reg aw_held;
reg w_held;
reg [4:0] aw_addr;
reg [7:0] w_byte;
reg w_lane;
assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
assign s_axi_wready = ~w_held & ~s_axi_bvalid;
wire do_write = aw_held & w_held & ~s_axi_bvalid;
wire wr_en = do_write & w_lane;
wire cnt_addr_w = (aw_addr == `ADDR_CNT_A_LOW) | (aw_addr == `ADDR_CNT_A_HIGH)
    | (aw_addr == `ADDR_CNT_B_LOW) | (aw_addr == `ADDR_CNT_B_HIGH);
wire wr_blocked = cnt_addr_w & run_bit;
wire wr_known = cnt_addr_w | (aw_addr == `ADDR_TIMER_CTRL)
    | (aw_addr == `ADDR_CONV_CFG) | (aw_addr == `ADDR_IRQ_CTRL);
wire wr_ok = wr_en & wr_known & ~wr_blocked;
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_addr <= 5'h00;
        w_byte <= `RESET_BYTE;
        w_lane <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RESP_OKAY;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane <= s_axi_wstrb[0];
        end
        if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_known && !wr_blocked) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end
// ****************************************************************
// AXI4-Lite read side
// ****************************************************************
assign s_axi_arready = ~s_axi_rvalid;
wire do_read = s_axi_arvalid & s_axi_arready;
wire rd_cnt = (s_axi_araddr == `ADDR_CNT_A_LOW) | (s_axi_araddr == `ADDR_CNT_A_HIGH)
    | (s_axi_araddr == `ADDR_CNT_B_LOW) | (s_axi_araddr == `ADDR_CNT_B_HIGH);
wire rd_blocked = rd_cnt & run_bit;
wire rd_ok = do_read & ~rd_blocked;
reg [7:0] rd_byte;
reg rd_known;
always @* begin
    rd_byte = `RESET_BYTE;
    rd_known = 1'b1;
    case (s_axi_araddr)
        `ADDR_CNT_A_LOW: rd_byte = buf_a;
        `ADDR_CNT_A_HIGH: rd_byte = cnt_a[15:8];
        `ADDR_CNT_B_LOW: rd_byte = buf_b;
        `ADDR_CNT_B_HIGH: rd_byte = cnt_b[15:8];
        `ADDR_TIMER_CTRL: begin
            rd_byte[`BIT_MODE_HI] = mode_sel_hi;
            rd_byte[`BIT_MODE_LO] = mode_sel_lo;
            rd_byte[`BIT_RUN] = run_bit;
            rd_byte[`BIT_EDGE_SEL] = edge_sel;
        end
        `ADDR_CONV_CFG: begin
            rd_byte[`BIT_OSC_CHANNEL_SEL] = osc_channel_sel;
            rd_byte[`BIT_CNT_B_SRC_SEL] = cnt_b_src_sel;
            rd_byte[`BIT_LIRC_EN] = lirc_en;
            rd_byte[`BIT_RC_PATH_SEL] = rc_path_sel;
            rd_byte[`BIT_CONVERTER_MODE] = converter_mode_bit;
            rd_byte[`BIT_OVERFLOW_SRC_SEL] = overflow_src_sel;
        end
        `ADDR_IRQ_CTRL: rd_byte[`BIT_OVERFLOW_FLAG] = flag;
        default: rd_known = 1'b0;
    endcase
end
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `RESP_OKAY;
    end else if (do_read) begin
        s_axi_rvalid <= 1'b1;
        // blocked counter reads return zero so no live value leaks out mid-count
        s_axi_rdata <= {24'h000000, (rd_blocked ? `RESET_BYTE : rd_byte)};
        s_axi_rresp <= (rd_known && !rd_blocked) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end
// ****************************************************************
// counters and low byte buffers
// ****************************************************************
always @(posedge aclk) begin
    if (!aresetn) begin
        cnt_a <= `RESET_WORD;
        cnt_b <= `RESET_WORD;
        buf_a <= `RESET_BYTE;
        buf_b <= `RESET_BYTE;
    end else begin
        // writes never coincide with counting: the bytes are locked while running
        if (inc_a) begin
            cnt_a <= cnt_a + 1'b1;
        end
        if (inc_b) begin
            cnt_b <= cnt_b + 1'b1;
        end
        if (wr_ok && aw_addr == `ADDR_CNT_A_LOW) begin
            buf_a <= w_byte;
        end
        if (wr_ok && aw_addr == `ADDR_CNT_A_HIGH) begin
            cnt_a <= {w_byte, buf_a};
        end
        if (wr_ok && aw_addr == `ADDR_CNT_B_LOW) begin
            buf_b <= w_byte;
        end
        if (wr_ok && aw_addr == `ADDR_CNT_B_HIGH) begin
            cnt_b <= {w_byte, buf_b};
        end
        if (rd_ok && s_axi_araddr == `ADDR_CNT_A_HIGH) begin
            buf_a <= cnt_a[7:0];
        end
        if (rd_ok && s_axi_araddr == `ADDR_CNT_B_HIGH) begin
            buf_b <= cnt_b[7:0];
        end
    end
end
// ****************************************************************
// control and configuration bits
// ****************************************************************
always @(posedge aclk) begin
    if (!aresetn) begin
        mode_sel_hi <= 1'b0;
        mode_sel_lo <= 1'b0;
        run_bit <= 1'b0;
        edge_sel <= 1'b0;
        osc_channel_sel <= 1'b0;
        cnt_b_src_sel <= 1'b0;
        lirc_en <= 1'b0;
        rc_path_sel <= 1'b0;
        converter_mode_bit <= 1'b0;
        overflow_src_sel <= 1'b0;
        flag <= 1'b0;
    end else begin
        if (wr_ok && aw_addr == `ADDR_TIMER_CTRL) begin
            mode_sel_hi <= w_byte[`BIT_MODE_HI];
            mode_sel_lo <= w_byte[`BIT_MODE_LO];
            run_bit <= w_byte[`BIT_RUN];
            edge_sel <= w_byte[`BIT_EDGE_SEL];
        end
        if (wr_ok && aw_addr == `ADDR_CONV_CFG) begin
            osc_channel_sel <= w_byte[`BIT_OSC_CHANNEL_SEL];
            cnt_b_src_sel <= w_byte[`BIT_CNT_B_SRC_SEL];
            lirc_en <= w_byte[`BIT_LIRC_EN];
            rc_path_sel <= w_byte[`BIT_RC_PATH_SEL];
            converter_mode_bit <= w_byte[`BIT_CONVERTER_MODE];
            overflow_src_sel <= w_byte[`BIT_OVERFLOW_SRC_SEL];
        end
        if (wr_ok && aw_addr == `ADDR_IRQ_CTRL) begin
            flag <= w_byte[`BIT_OVERFLOW_FLAG];
        end
        // overflow wins over a software write in the same cycle
        if (ovf) begin
            flag <= 1'b1;
            run_bit <= 1'b0;
        end
    end
end
endmodule // rc_dual_counter_adc
`default_nettype wire

// ===== tb/rc_adc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// port checker
// ****************************************************************
module rc_adc_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic res_freq_osc0_en,
    input wire logic res_freq_osc1_en,
    input wire logic sensor_resistor_path,
    input wire logic overflow_irq_flag
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // software writes land on the edge that raises bvalid
    sequence s_wr_done;
        $rose(s_axi_bvalid);
    endsequence
    AST_B_ANSWER: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed");
    AST_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    AST_R_REFUSE: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0)
        else $error("refused read returned data");
    AST_PATH_WR: assert property ($changed(sensor_resistor_path) |-> s_wr_done)
        else $error("path changed without write");
    AST_OSC_EXCL: assert property (!(res_freq_osc0_en && res_freq_osc1_en))
        else $error("both oscillators on");
    AST_STOP: assert property ($rose(overflow_irq_flag) && !$rose(s_axi_bvalid) |-> !res_freq_osc0_en && !res_freq_osc1_en)
        else $error("oscillator left on after stop");
    AST_FLAG_KEEP: assert property ($fell(overflow_irq_flag) |-> s_wr_done)
        else $error("flag cleared by itself");
    AST_EN_WR: assert property ($rose(res_freq_osc0_en) || $rose(res_freq_osc1_en) |-> s_wr_done)
        else $error("oscillator started without write");
endmodule // rc_adc_monitor
bind rc_dual_counter_adc rc_adc_monitor u_mon (.*);
`default_nettype wire

// ===== tb/rc_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// far-side oscillators
// ****************************************************************
module rc_osc_model (
    input wire logic en0,
    input wire logic en1,
    input wire logic lirc_en,
    output logic o0,
    output logic o1,
    output logic ol
);
    initial begin
        o0 = 1'h0;
        o1 = 1'h0;
        ol = 1'h0;
    end
    // a powered-down oscillator stands still, it does not free-run
    always #35 o0 = en0 ? ~o0 : o0;
    always #90 o1 = en1 ? ~o1 : o1;
    always #110 ol = lirc_en ? ~ol : ol;
endmodule // rc_osc_model
`default_nettype wire

// ===== tb/rc_dual_counter_adc_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rc_adc_defines.vh"
// ****************************************************************
// bench
// ****************************************************************
module rc_dual_counter_adc_tb;
logic aclk = 1'h0;
logic aresetn = 1'h0;
logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
logic [31:0] s_axi_wdata = 32'h0;
logic [3:0] s_axi_wstrb = 4'h1;
logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
wire low_speed_rc_osc, res_freq_osc0, res_freq_osc1, overflow_irq_flag;
wire res_freq_osc0_en, res_freq_osc1_en, low_speed_rc_osc_en, sensor_resistor_path;
integer error_cnt = 0, total_checks = 0, cycles = 0, i, k, t;
logic [31:0] rv;
logic [7:0] lo, hi, cfg, ctl;
logic [15:0] ld, v;
logic [4:0] base, a;
localparam logic [55:0] CFGS = 56'h42c72243400041;
localparam logic [55:0] CTLS = 56'h50385070305010;
localparam logic [6:0] OVFS = 7'h78;
always #10 aclk = ~aclk;
rc_dual_counter_adc u_dut (.*);
rc_osc_model u_osc (.en0(res_freq_osc0_en), .en1(res_freq_osc1_en), .lirc_en(low_speed_rc_osc_en),
    .o0(res_freq_osc0), .o1(res_freq_osc1), .ol(low_speed_rc_osc));
task finish_test;
    if (error_cnt == 0 && total_checks > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask
always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
        error_cnt = error_cnt + 1;
        finish_test;
    end
end
task chk(input string n, input [31:0] e, input [31:0] g);
    total_checks++;
    if (g !== e) begin
        error_cnt++;
        $display("wrong value %s exp %h got %h", n, e, g);
    end
endtask
task wr(input [4:0] ad, input [7:0] d, input [1:0] er);
    logic late, done;
    // answer ready raised late at random so the hold checks see a wait
    late = 1'($urandom);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= !late;
    do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
        done = s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1;
        if (s_axi_bvalid === 1'h1 && !done) s_axi_bready <= 1'h1;
    end while (!done);
    s_axi_bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
endtask
task rd(input [4:0] ad, input [7:0] ed, input [1:0] er);
    logic late, done;
    late = 1'($urandom);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= !late;
    do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
        done = s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1;
        if (s_axi_rvalid === 1'h1 && !done) s_axi_rready <= 1'h1;
    end while (!done);
    s_axi_rready <= 1'h0;
    chk("rdata", {24'h0, ed}, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
endtask
// oscillator power expected from mode, converter, source and channel bits
function logic [1:0] exp_en(input [7:0] c, input [7:0] m);
    logic on;
    on = m[4] && (m[5] || (m[6:5] == `MODE_TIMER && c[1] && c[6]));
    return {on && c[7], on && !c[7]};
endfunction
initial begin
    rv = $urandom(32'h400d89a2);
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`ADDR_TIMER_CTRL, 8'h00, `RESP_OKAY);
    rd(`ADDR_CONV_CFG, 8'h00, `RESP_OKAY);
    rd(`ADDR_IRQ_CTRL, 8'h00, `RESP_OKAY);
    wr(5'h1c, 8'h11, `RESP_SLVERR);
    rd(5'h1c, 8'h00, `RESP_SLVERR);
    // a write with the low byte lane off is answered but stores nothing
    s_axi_wstrb <= 4'h0;
    wr(`ADDR_IRQ_CTRL, 8'h10, `RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    rd(`ADDR_IRQ_CTRL, 8'h00, `RESP_OKAY);
    wr(`ADDR_CONV_CFG, 8'h02, `RESP_OKAY);
    for (i = 0; i < 2; i++) begin
        base = i ? `ADDR_CNT_B_LOW : `ADDR_CNT_A_LOW;
        lo = 8'($urandom);
        hi = 8'($urandom);
        wr(base, lo, `RESP_OKAY);
        rd(base | 5'h04, 8'h00, `RESP_OKAY);
        rd(base, 8'h00, `RESP_OKAY);
        wr(base, lo, `RESP_OKAY);
        wr(base | 5'h04, hi, `RESP_OKAY);
        rd(base | 5'h04, hi, `RESP_OKAY);
        rd(base, lo, `RESP_OKAY);
    end
    for (k = 0; k < 7; k++) begin
        cfg = CFGS[(6 - k) * 8 +: 8];
        ctl = CTLS[(6 - k) * 8 +: 8];
        base = cfg[0] ? `ADDR_CNT_B_LOW : `ADDR_CNT_A_LOW;
        ld = OVFS[6 - k] ? 16'hff80 | {10'h0, 6'($urandom)} : 16'($urandom);
        wr(`ADDR_CONV_CFG, cfg, `RESP_OKAY);
        chk("path", {31'h0, cfg[2]}, {31'h0, sensor_resistor_path});
        chk("lirc_en", {31'h0, cfg[5]}, {31'h0, low_speed_rc_osc_en});
        for (i = 0; i < 2; i++) begin
            a = i ? `ADDR_CNT_B_LOW : `ADDR_CNT_A_LOW;
            v = (a == base) ? ld : 16'h0;
            wr(a, v[7:0], `RESP_OKAY);
            wr(a | 5'h04, v[15:8], `RESP_OKAY);
        end
        if (ctl[6:5] == `MODE_EVENT)
            wr(`ADDR_TIMER_CTRL, ctl & 8'hf7, `RESP_OKAY);
        wr(`ADDR_TIMER_CTRL, ctl, `RESP_OKAY);
        chk("osc_en", {30'h0, exp_en(cfg, ctl)},
            {30'h0, res_freq_osc1_en, res_freq_osc0_en});
        if (OVFS[6 - k]) begin
            rd(base | 5'h04, 8'h00, `RESP_SLVERR);
            wr(base, 8'h5a, `RESP_SLVERR);
            t = 0;
            while (overflow_irq_flag !== 1'h1 && t < 3000) begin
                @(posedge aclk);
                t++;
            end
            chk("flag", 32'h1, {31'h0, overflow_irq_flag});
            chk("osc_off", 32'h0, {30'h0, res_freq_osc1_en, res_freq_osc0_en});
            rd(`ADDR_TIMER_CTRL, ctl & 8'hef, `RESP_OKAY);
            rd(`ADDR_IRQ_CTRL, 8'h10, `RESP_OKAY);
            rd(base | 5'h04, 8'h00, `RESP_OKAY);
            rd(base, 8'h00, `RESP_OKAY);
            wr(`ADDR_IRQ_CTRL, 8'h00, `RESP_OKAY);
            chk("flag_clr", 32'h0, {31'h0, overflow_irq_flag});
        end else begin
            repeat (40) @(posedge aclk);
            chk("no_flag", 32'h0, {31'h0, overflow_irq_flag});
            wr(`ADDR_TIMER_CTRL, 8'h00, `RESP_OKAY);
            rd(base | 5'h04, ld[15:8], `RESP_OKAY);
            rd(base, ld[7:0], `RESP_OKAY);
        end
    end
    finish_test;
end
endmodule // rc_dual_counter_adc_tb
`default_nettype wire
